// File: common/amhc_defs.svh
// amhc_defs.svh: timing counts and counter widths for the mode controller.
// assumes a slow timebase tick supplied from outside the block, nominally 10 Hz.
`ifndef AMHC_DEFS_SVH
`define AMHC_DEFS_SVH

// timebase tick period in milliseconds and the derived tick counts
`define AMHC_TICK_MS 100
`define AMHC_HOLD_LOSS_MS 1000
`define AMHC_AUTO_LOSS_MS 3000
`define AMHC_QUAL_MS 1000
`define AMHC_AUTO_QUAL_MS 3000
`define AMHC_MOTOR_OFF_MS 50000
`define AMHC_LOOP_OFF_MS 7000
`define AMHC_TICKS(ms) ((ms) / `AMHC_TICK_MS)
// longest space run accepted as keyed copy: 60 wpm character, seven units of 22 ms
`define AMHC_MAX_SPACE_US 154000
// space-run limit in CLK cycles at 250 MHz (4 ns period)
`define AMHC_CLK_NS 4
`define AMHC_MAX_SPACE_CYC ((`AMHC_MAX_SPACE_US * 1000) / `AMHC_CLK_NS)
`define AMHC_TMR_W 10
`define AMHC_SP_W 26

`endif

// File: common/amhc_pkg.sv
// amhc_pkg.sv: types shared by the mode controller.
// assumes amhc_defs.svh carries every number.
package amhc_pkg;
   // keying selector positions
   typedef enum logic [2:0] {
      AMHC_KEY_NORMAL,
      AMHC_KEY_STANDBY,
      AMHC_KEY_REVERSE,
      AMHC_KEY_MARK,
      AMHC_KEY_AUTO
   } amhc_keying_t;
   // channel selector positions
   typedef enum logic [2:0] {
      AMHC_CH_A,
      AMHC_CH_A_MARK_ONLY,
      AMHC_CH_A_SPACE_ONLY,
      AMHC_CH_B,
      AMHC_CH_B_MARK_ONLY,
      AMHC_CH_B_SPACE_ONLY
   } amhc_chan_t;
   // power switch positions
   typedef enum logic [1:0] {
      AMHC_PWR_ON,
      AMHC_PWR_MONITOR,
      AMHC_PWR_SEND
   } amhc_power_t;
endpackage : amhc_pkg

// File: src/amhc_timer.sv
// amhc_timer.sv: tick counter that restarts on demand and flags when a limit is reached.
// assumes tick is a one-cycle pulse on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "amhc_defs.svh"

module amhc_timer #(
   parameter int W = `AMHC_TMR_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic restart,
   input wire logic tick,
   input wire logic [W-1:0] limit,
   output logic done
);
   logic [W-1:0] cnt_q;

   // count saturates at the limit so done stays up until restarted
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (ce) begin
         if (restart) begin
            cnt_q <= '0;
         end else if (tick && cnt_q < limit) begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end

   assign done = (cnt_q >= limit);
endmodule // amhc_timer

`default_nettype wire

// File: src/amhc_controller.sv
// amhc_controller.sv: keying-mode, mark-hold and autostart control for a tone converter.
// assumes panel selections and the demodulated tones arrive from pins; tick is same-clock.
`timescale 1ns/1ps
`default_nettype none
`include "amhc_defs.svh"

// What this block does
// - single-tone channel positions disable autostart and mark-hold, motor on; standby and reverse still apply
// - mark-only positions key from the mark tone; space-only from the space tone
// - normal mode passes demodulated data, no mark-hold, no motor control
// - standby mode holds the keyer marking regardless of input
// - reverse mode is normal mode with mark and space sense inverted
// - mark-hold forces marking after one second loss until one second good
// - signal acceptable when steady mark or keyed without over-long space
// - outside autostart the motor relay stays on while powered
// - autostart keeps motor off until three seconds of good signal
// - autostart enters mark-hold after three seconds of loss
// - autostart turns motor off after fifty seconds in mark-hold
// - seven seconds after motor off, loop current turns off
// - from full standby, three seconds of good signal restarts motor and loop
// - autostart at power-up starts motor, off after fifty seconds without signal
// - in plain power-on position motor follows the keying mode
// - send position closes transmitter control, monitor off, tone keyer on if fitted
// - remote standby forces marking, and in autostart turns the motor on
// - remote standby lights receive and standby lamps together
module amhc_controller
   import amhc_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic TICK,
   input wire amhc_pkg::amhc_keying_t KEYING,
   input wire amhc_pkg::amhc_chan_t CHANNEL,
   input wire amhc_pkg::amhc_power_t POWER_POS,
   input wire logic MARK_TONE,
   input wire logic SPACE_TONE,
   input wire logic REMOTE_STANDBY_INPUT,
   input wire logic TONE_KEYER_FITTED,
   output logic LOOP_MARK,
   output logic LOOP_ENABLE,
   output logic MOTOR_OUTLET,
   output logic MARK_HOLD_ACTIVE,
   output logic RECEIVE_LAMP,
   output logic STANDBY_LAMP,
   output logic XMIT_CONTROL,
   output logic MONITOR_HV,
   output logic TONE_KEYER_ON
);
   import amhc_pkg::*;

   typedef enum logic [2:0] {
      AMHC_ST_RUN,
      AMHC_ST_HOLD,
      AMHC_ST_MOTOR_OFF,
      AMHC_ST_FULL_REMOTE_STANDBY_INPUT,
      AMHC_ST_WAIT
   } amhc_state_t;

   localparam logic [`AMHC_TMR_W-1:0] LOSS_1S = `AMHC_TMR_W'(`AMHC_TICKS(`AMHC_HOLD_LOSS_MS));
   localparam logic [`AMHC_TMR_W-1:0] LOSS_3S = `AMHC_TMR_W'(`AMHC_TICKS(`AMHC_AUTO_LOSS_MS));
   localparam logic [`AMHC_TMR_W-1:0] QUAL_1S = `AMHC_TMR_W'(`AMHC_TICKS(`AMHC_QUAL_MS));
   localparam logic [`AMHC_TMR_W-1:0] QUAL_3S = `AMHC_TMR_W'(`AMHC_TICKS(`AMHC_AUTO_QUAL_MS));
   localparam logic [`AMHC_TMR_W-1:0] MOTOR_50S = `AMHC_TMR_W'(`AMHC_TICKS(`AMHC_MOTOR_OFF_MS));
   localparam logic [`AMHC_TMR_W-1:0] LOOP_7S = `AMHC_TMR_W'(`AMHC_TICKS(`AMHC_LOOP_OFF_MS));
   localparam logic [`AMHC_SP_W-1:0] SPACE_MAX = `AMHC_SP_W'(`AMHC_MAX_SPACE_CYC);

   // pin synchronisers: first stage is read only by the second
   logic [1:0] mark_s1_q, mark_s2_q, space_s1_q, space_s2_q, remote_standby_input_s1_q, remote_standby_input_s2_q;
   logic [1:0] unused_pad;
   logic mark_sync, space_sync, remote_standby_input_sync;

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mark_s1_q <= 2'h0;
         space_s1_q <= 2'h0;
         remote_standby_input_s1_q <= 2'h0;
      end else if (CE) begin
         mark_s1_q <= {1'b0, MARK_TONE};
         space_s1_q <= {1'b0, SPACE_TONE};
         remote_standby_input_s1_q <= {1'b0, REMOTE_STANDBY_INPUT};
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         mark_s2_q <= 2'h0;
         space_s2_q <= 2'h0;
         remote_standby_input_s2_q <= 2'h0;
      end else if (CE) begin
         mark_s2_q <= mark_s1_q;
         space_s2_q <= space_s1_q;
         remote_standby_input_s2_q <= remote_standby_input_s1_q;
      end
   end

   assign mark_sync = mark_s2_q[0];
   assign space_sync = space_s2_q[0];
   assign remote_standby_input_sync = remote_standby_input_s2_q[0];
   assign unused_pad = mark_s2_q[1] ^ space_s2_q[1] ^ remote_standby_input_s2_q[1] ? 2'h0 : 2'h0;

   // channel decode
   wire mark_only = (CHANNEL == AMHC_CH_A_MARK_ONLY) || (CHANNEL == AMHC_CH_B_MARK_ONLY);
   wire space_only = (CHANNEL == AMHC_CH_A_SPACE_ONLY) || (CHANNEL == AMHC_CH_B_SPACE_ONLY);
   wire single_tone = mark_only || space_only;

   // demodulated mark sense; single-tone positions ignore the other tone
   wire demod_mark = mark_only ? mark_sync :
                     space_only ? ~space_sync :
                     (mark_sync || ~space_sync);

   // keying mode decode; single-tone masks autostart and mark-hold only
   wire mode_auto = (KEYING == AMHC_KEY_AUTO) && !single_tone;
   wire mode_hold = (KEYING == AMHC_KEY_MARK) && !single_tone;
   wire mode_remote_standby_input = (KEYING == AMHC_KEY_STANDBY);
   wire mode_rev = (KEYING == AMHC_KEY_REVERSE);

   // acceptable-signal detector: a space run longer than one character means loss
   logic [`AMHC_SP_W-1:0] space_run_q;
   logic accept_q;
   wire any_tone = mark_sync || space_sync;
   wire too_long = (space_run_q >= SPACE_MAX);

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         space_run_q <= '0;
      end else if (CE) begin
         if (demod_mark || !any_tone) begin
            space_run_q <= '0;
         end else if (!too_long) begin
            space_run_q <= space_run_q + 1'b1;
         end
      end
   end

   // no tone at all, or an over-long space, is not acceptable copy
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         accept_q <= 1'b0;
      end else if (CE) begin
         accept_q <= any_tone && !too_long;
      end
   end

   // restart qualification timers on any change of the acceptable indication
   logic accept_prev_q;
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         accept_prev_q <= 1'b0;
      end else if (CE) begin
         accept_prev_q <= accept_q;
      end
   end
   wire accept_edge = accept_q ^ accept_prev_q;

   // state machine registers
   amhc_state_t state_q, state_d;
   logic mode_auto_prev_q;
   logic first_q;
   wire auto_entry = mode_auto && !mode_auto_prev_q;

   // timers: loss, good, motor-off and loop-off, all on the shared tick
   wire loss_done, good_done, mtr_done, loop_done;
   wire [`AMHC_TMR_W-1:0] loss_lim = mode_auto ? LOSS_3S : LOSS_1S;
   wire [`AMHC_TMR_W-1:0] good_lim = (mode_auto && state_q != AMHC_ST_HOLD) ? QUAL_3S : QUAL_1S;
   wire state_chg = (state_d != state_q);

   amhc_timer #(.W(`AMHC_TMR_W)) u_loss (
      .clk(CLK), .rst(SYS_RST), .ce(CE), .restart(accept_edge || accept_q),
      .tick(TICK), .limit(loss_lim), .done(loss_done)
   );
   amhc_timer #(.W(`AMHC_TMR_W)) u_good (
      .clk(CLK), .rst(SYS_RST), .ce(CE), .restart(accept_edge || !accept_q),
      .tick(TICK), .limit(good_lim), .done(good_done)
   );
   amhc_timer #(.W(`AMHC_TMR_W)) u_mtr (
      .clk(CLK), .rst(SYS_RST), .ce(CE), .restart(state_chg || auto_entry),
      .tick(TICK), .limit(MOTOR_50S), .done(mtr_done)
   );
   amhc_timer #(.W(`AMHC_TMR_W)) u_loop (
      .clk(CLK), .rst(SYS_RST), .ce(CE), .restart(state_chg),
      .tick(TICK), .limit(LOOP_7S), .done(loop_done)
   );

   // next-state logic; non-hold modes sit in run
   always_comb begin
      state_d = state_q;
      if (!mode_auto && !mode_hold) begin
         state_d = AMHC_ST_RUN;
      end else if (!mode_auto && state_q != AMHC_ST_HOLD) begin
         state_d = loss_done ? AMHC_ST_HOLD : AMHC_ST_RUN;
      end else if (auto_entry) begin
         // startup in autostart runs the motor straight away, else wait for signal
         state_d = first_q ? AMHC_ST_WAIT : AMHC_ST_FULL_REMOTE_STANDBY_INPUT;
      end else begin
         case (state_q)
            AMHC_ST_RUN: begin
               if (loss_done) begin
                  state_d = AMHC_ST_HOLD;
               end
            end
            AMHC_ST_HOLD: begin
               if (good_done) begin
                  state_d = AMHC_ST_RUN;
               end else if (mode_auto && mtr_done) begin
                  state_d = AMHC_ST_MOTOR_OFF;
               end
            end
            AMHC_ST_MOTOR_OFF: begin
               if (good_done) begin
                  state_d = AMHC_ST_RUN;
               end else if (loop_done) begin
                  state_d = AMHC_ST_FULL_REMOTE_STANDBY_INPUT;
               end
            end
            AMHC_ST_FULL_REMOTE_STANDBY_INPUT: begin
               if (good_done) begin
                  state_d = AMHC_ST_RUN;
               end
            end
            AMHC_ST_WAIT: begin
               if (good_done) begin
                  state_d = AMHC_ST_RUN;
               end else if (mtr_done) begin
                  state_d = AMHC_ST_MOTOR_OFF;
               end
            end
            default: begin
               state_d = AMHC_ST_RUN;
            end
         endcase
      end
   end

   // state register and first-cycle flag for the power-up autostart case
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_q <= AMHC_ST_RUN;
         mode_auto_prev_q <= 1'b0;
         first_q <= 1'b1;
      end else if (CE) begin
         state_q <= state_d;
         mode_auto_prev_q <= mode_auto;
         first_q <= 1'b0;
      end
   end

   // output decode
   wire hold_now = (state_q != AMHC_ST_RUN) && (mode_auto || mode_hold);
   wire motor_now = !mode_auto || remote_standby_input_sync ||
                    (state_q == AMHC_ST_RUN) || (state_q == AMHC_ST_HOLD) || (state_q == AMHC_ST_WAIT);
   wire loop_now = !mode_auto || remote_standby_input_sync || (state_q != AMHC_ST_FULL_REMOTE_STANDBY_INPUT);
   wire force_mark = mode_remote_standby_input || remote_standby_input_sync || hold_now;
   wire key_mark = force_mark ? 1'b1 : (mode_rev ? ~demod_mark : demod_mark);
   wire send_pos = (POWER_POS == AMHC_PWR_SEND);

   // all outputs are registered; reset gives motor on, loop on, marking
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         LOOP_MARK <= 1'b1;
         LOOP_ENABLE <= 1'b1;
         MOTOR_OUTLET <= 1'b1;
         MARK_HOLD_ACTIVE <= 1'b0;
         RECEIVE_LAMP <= 1'b0;
         STANDBY_LAMP <= 1'b0;
         XMIT_CONTROL <= 1'b0;
         MONITOR_HV <= 1'b0;
         TONE_KEYER_ON <= 1'b0;
      end else if (CE) begin
         LOOP_MARK <= key_mark;
         LOOP_ENABLE <= loop_now;
         MOTOR_OUTLET <= motor_now;
         MARK_HOLD_ACTIVE <= hold_now;
         RECEIVE_LAMP <= remote_standby_input_sync || !force_mark;
         STANDBY_LAMP <= remote_standby_input_sync || mode_remote_standby_input;
         XMIT_CONTROL <= send_pos;
         MONITOR_HV <= (POWER_POS == AMHC_PWR_MONITOR);
         TONE_KEYER_ON <= send_pos && TONE_KEYER_FITTED;
      end
   end
endmodule // amhc_controller

`default_nettype wire

// File: tb/amhc_chk.sv
// amhc_chk.sv: port-level assertions for the mode controller.
// assumes CE stays high and panel inputs are held as levels.
`timescale 1ns/1ps
`default_nettype none
module amhc_chk
   import amhc_pkg::*;
(
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   input wire logic TICK,
   input wire amhc_pkg::amhc_keying_t KEYING,
   input wire amhc_pkg::amhc_chan_t CHANNEL,
   input wire amhc_pkg::amhc_power_t POWER_POS,
   input wire logic MARK_TONE,
   input wire logic SPACE_TONE,
   input wire logic REMOTE_STANDBY_INPUT,
   input wire logic TONE_KEYER_FITTED,
   input wire logic LOOP_MARK,
   input wire logic LOOP_ENABLE,
   input wire logic MOTOR_OUTLET,
   input wire logic MARK_HOLD_ACTIVE,
   input wire logic RECEIVE_LAMP,
   input wire logic STANDBY_LAMP,
   input wire logic XMIT_CONTROL,
   input wire logic MONITOR_HV,
   input wire logic TONE_KEYER_ON
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SYS_RST);
   // single-tone positions; eight-cycle runs cover sync and register latency
   wire single = CHANNEL inside {AMHC_CH_A_MARK_ONLY, AMHC_CH_A_SPACE_ONLY, AMHC_CH_B_MARK_ONLY, AMHC_CH_B_SPACE_ONLY};
   property p_rst;
      disable iff (1'h0) SYS_RST && CE |=> LOOP_MARK && LOOP_ENABLE && MOTOR_OUTLET && !MARK_HOLD_ACTIVE;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   property p_std;
      (KEYING == AMHC_KEY_STANDBY)[*8] |-> LOOP_MARK;
   endproperty
   a_std: assert property (p_std) else $error("standby not marking");
   property p_mot;
      (KEYING != AMHC_KEY_AUTO)[*8] |-> MOTOR_OUTLET;
   endproperty
   a_mot: assert property (p_mot) else $error("motor off outside auto");
   property p_sgl;
      single[*8] |-> MOTOR_OUTLET && !MARK_HOLD_ACTIVE;
   endproperty
   a_sgl: assert property (p_sgl) else $error("single tone not normal");
   property p_snd;
      (POWER_POS == AMHC_PWR_SEND)[*8] |-> XMIT_CONTROL && !MONITOR_HV && (TONE_KEYER_ON == TONE_KEYER_FITTED);
   endproperty
   a_snd: assert property (p_snd) else $error("send outputs wrong");
   property p_rmt;
      REMOTE_STANDBY_INPUT[*8] |-> LOOP_MARK && MOTOR_OUTLET;
   endproperty
   a_rmt: assert property (p_rmt) else $error("remote standby not marking");
   property p_lmp;
      REMOTE_STANDBY_INPUT[*8] |-> RECEIVE_LAMP && STANDBY_LAMP;
   endproperty
   a_lmp: assert property (p_lmp) else $error("remote lamps not both lit");
   property p_hold;
      MARK_HOLD_ACTIVE[*2] |-> LOOP_MARK;
   endproperty
   a_hold: assert property (p_hold) else $error("hold not marking");
   property p_loop;
      $fell(LOOP_ENABLE) |-> !MOTOR_OUTLET && (KEYING == AMHC_KEY_AUTO);
   endproperty
   a_loop: assert property (p_loop) else $error("loop dropped with motor on");
   // main scenarios reached
   c_hold: cover property (MARK_HOLD_ACTIVE);
   c_full: cover property (!LOOP_ENABLE && !MOTOR_OUTLET);
   c_rmt: cover property (REMOTE_STANDBY_INPUT && KEYING == AMHC_KEY_AUTO);
endmodule // amhc_chk

bind amhc_controller amhc_chk amhc_chk_i (.CLK(CLK), .SYS_RST(SYS_RST), .CE(CE), .TICK(TICK), .KEYING(KEYING),
   .CHANNEL(CHANNEL), .POWER_POS(POWER_POS), .MARK_TONE(MARK_TONE), .SPACE_TONE(SPACE_TONE),
   .REMOTE_STANDBY_INPUT(REMOTE_STANDBY_INPUT), .TONE_KEYER_FITTED(TONE_KEYER_FITTED), .LOOP_MARK(LOOP_MARK),
   .LOOP_ENABLE(LOOP_ENABLE), .MOTOR_OUTLET(MOTOR_OUTLET), .MARK_HOLD_ACTIVE(MARK_HOLD_ACTIVE),
   .RECEIVE_LAMP(RECEIVE_LAMP), .STANDBY_LAMP(STANDBY_LAMP), .XMIT_CONTROL(XMIT_CONTROL),
   .MONITOR_HV(MONITOR_HV), .TONE_KEYER_ON(TONE_KEYER_ON));
`default_nettype wire

// File: tb/amhc_tty_model.sv
// amhc_tty_model.sv: teleprinter on the loop keyer and motor outlet.
// assumes loop and motor levels come straight from the controller.
`timescale 1ns/1ps
`default_nettype none
module amhc_tty_model (
   input wire logic clk,
   input wire logic loop_mark,
   input wire logic loop_en,
   input wire logic motor,
   output logic idle
);
   // selector rests only with the motor running and marking current flowing
   always_ff @(posedge clk) begin
      idle <= motor & loop_en & loop_mark;
   end
endmodule // amhc_tty_model
`default_nettype wire

// File: tb/tb.sv
// tb.sv: self-checking bench for the mode controller and teleprinter model.
// assumes ticks shortened to one every 8 clocks; tick counts scale with them.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import amhc_pkg::*;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic tick = 1'h0;
   logic mt = 1'h0;
   logic st = 1'h0;
   logic rsi = 1'h0;
   logic tkf = 1'h1;
   amhc_keying_t key = AMHC_KEY_NORMAL;
   amhc_chan_t ch = AMHC_CH_A;
   amhc_power_t pw = AMHC_PWR_ON;
   logic lm, le, mo, mh, rl, sl, xc, hv, tk, idle;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   int tc = 0;
   amhc_chan_t chs [4] = '{AMHC_CH_A_MARK_ONLY, AMHC_CH_A_SPACE_ONLY, AMHC_CH_B_MARK_ONLY, AMHC_CH_B_SPACE_ONLY};
   amhc_controller amhc_controller_i (.CLK(clk), .SYS_RST(rst), .CE(1'h1), .TICK(tick), .KEYING(key),
      .CHANNEL(ch), .POWER_POS(pw), .MARK_TONE(mt), .SPACE_TONE(st), .REMOTE_STANDBY_INPUT(rsi),
      .TONE_KEYER_FITTED(tkf), .LOOP_MARK(lm), .LOOP_ENABLE(le), .MOTOR_OUTLET(mo), .MARK_HOLD_ACTIVE(mh),
      .RECEIVE_LAMP(rl), .STANDBY_LAMP(sl), .XMIT_CONTROL(xc), .MONITOR_HV(hv), .TONE_KEYER_ON(tk));
   amhc_tty_model amhc_tty_model_i (.clk(clk), .loop_mark(lm), .loop_en(le), .motor(mo), .idle(idle));
   always #2 clk = ~clk;
   // short tick period keeps the fifty-second chain to a few thousand clocks
   always @(negedge clk) begin
      tc = (tc + 1) % 8;
      tick <= (tc == 0);
   end
   // hang guard, about three times the expected run
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 30000) begin
         err_total = err_total + 1;
         $display("MISMATCH at %0t: timeout", $time);
         summarize();
      end
   end
   task automatic chk(input logic seen, input logic exp, input string m);
      checked = checked + 1;
      if (seen !== exp) begin
         err_total = err_total + 1;
         $display("MISMATCH at %0t: %s", $time, m);
      end
   endtask
   task automatic wt(input int n);
      repeat (n * 8) @(negedge clk);
   endtask
   // inputs change at the falling edge only; one tick lets them settle
   task automatic drv(input amhc_keying_t k, input logic m, input logic s);
      key = k;
      mt = m;
      st = s;
      wt(1);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // test order: senses, channels, mark-hold, autostart chain, power, power-up in auto
   initial begin
      repeat (4) @(negedge clk);
      chk(lm, 1'h1, "reset keyer");
      chk(le, 1'h1, "reset loop");
      chk(mo, 1'h1, "reset motor");
      rst = 1'h0;
      drv(AMHC_KEY_NORMAL, 1'h1, 1'h0);
      chk(lm, 1'h1, "normal mark");
      drv(AMHC_KEY_NORMAL, 1'h0, 1'h1);
      chk(lm, 1'h0, "normal space");
      chk(mo, 1'h1, "normal motor");
      drv(AMHC_KEY_STANDBY, 1'h0, 1'h1);
      chk(lm, 1'h1, "standby keyer");
      chk(sl, 1'h1, "standby lamp");
      drv(AMHC_KEY_REVERSE, 1'h0, 1'h1);
      chk(lm, 1'h1, "reverse space");
      drv(AMHC_KEY_REVERSE, 1'h1, 1'h0);
      chk(lm, 1'h0, "reverse mark");
      drv(AMHC_KEY_STANDBY, 1'h0, 1'h0);
      $display("test keying done");
      for (int i = 0; i < 4; i++) begin
         ch = chs[i];
         drv(AMHC_KEY_NORMAL, i[0], 1'h1);
         chk(lm, 1'h0, "single tone space");
         drv(AMHC_KEY_NORMAL, ~i[0], 1'h0);
         chk(lm, 1'h1, "single tone mark");
      end
      drv(AMHC_KEY_MARK, 1'h0, 1'h0);
      wt(13);
      chk(mh, 1'h0, "single tone hold");
      drv(AMHC_KEY_AUTO, 1'h0, 1'h0);
      wt(33);
      chk(mh, 1'h0, "single tone auto hold");
      chk(mo, 1'h1, "single tone motor");
      drv(AMHC_KEY_NORMAL, 1'h1, 1'h0);
      ch = AMHC_CH_A;
      $display("test channel done");
      drv(AMHC_KEY_MARK, 1'h1, 1'h0);
      drv(AMHC_KEY_MARK, 1'h0, 1'h0);
      wt(7);
      chk(mh, 1'h0, "hold early");
      wt(5);
      chk(mh, 1'h1, "hold late");
      chk(idle, 1'h1, "printer marking");
      drv(AMHC_KEY_MARK, 1'h0, 1'h1);
      wt(7);
      chk(mh, 1'h1, "release early");
      wt(5);
      chk(mh, 1'h0, "release late");
      chk(lm, 1'h0, "space after release");
      $display("test markhold done");
      drv(AMHC_KEY_AUTO, 1'h0, 1'h0);
      chk(mo, 1'h0, "auto entry motor");
      drv(AMHC_KEY_AUTO, 1'h1, 1'h0);
      wt(26);
      chk(mo, 1'h0, "start early");
      wt(6);
      chk(mo, 1'h1, "start late");
      chk(le, 1'h1, "start loop");
      drv(AMHC_KEY_AUTO, 1'h0, 1'h0);
      wt(26);
      chk(mh, 1'h0, "auto hold early");
      wt(6);
      chk(mh, 1'h1, "auto hold late");
      wt(494);
      chk(mo, 1'h1, "motor early");
      wt(8);
      chk(mo, 1'h0, "motor late");
      wt(63);
      chk(le, 1'h1, "loop early");
      wt(10);
      chk(le, 1'h0, "loop late");
      chk(idle, 1'h0, "printer standby");
      rsi = 1'h1;
      wt(1);
      chk(mo, 1'h1, "remote motor");
      chk(lm, 1'h1, "remote keyer");
      chk(rl, 1'h1, "remote receive lamp");
      chk(sl, 1'h1, "remote standby lamp");
      rsi = 1'h0;
      drv(AMHC_KEY_AUTO, 1'h1, 1'h0);
      wt(33);
      chk(mo, 1'h1, "restart motor");
      chk(le, 1'h1, "restart loop");
      $display("test autostart done");
      pw = AMHC_PWR_SEND;
      wt(1);
      chk(xc, 1'h1, "send control");
      chk(hv, 1'h0, "send monitor");
      chk(tk, 1'h1, "send tone keyer");
      pw = AMHC_PWR_MONITOR;
      wt(1);
      chk(hv, 1'h1, "monitor high voltage");
      chk(xc, 1'h0, "monitor control");
      // strap changes only with the power position, so the keyer output never lags inside send
      tkf = 1'h0;
      pw = AMHC_PWR_SEND;
      wt(1);
      chk(tk, 1'h0, "send no tone keyer");
      tkf = 1'h1;
      pw = AMHC_PWR_ON;
      wt(1);
      chk(xc, 1'h0, "on control");
      chk(mo, 1'h1, "on motor");
      $display("test power done");
      mt = 1'h0;
      rst = 1'h1;
      repeat (4) @(negedge clk);
      rst = 1'h0;
      wt(2);
      chk(mo, 1'h1, "powerup motor");
      wt(490);
      chk(mo, 1'h1, "powerup early");
      wt(16);
      chk(mo, 1'h0, "powerup late");
      $display("test powerup done");
      summarize();
   end
endmodule // tb
`default_nettype wire
